// ===== dpha_dev_model.sv
// Purpose: Behavioural model of one device port as the host sees it.
// Assumes: The bench plays the other port through busy_force, other_holds and other_on.
// Notes: Clockless; a released data bus shows the inverse of its last value.

`timescale 1ns/10ps
`default_nettype none

module dpha_dev_model
   import dpha_pkg::*;
#(
   parameter int ACC_NS = 25  // Read access delay; raise it for a slow part
) (
   // Port pins
   input wire logic [ADDR_W-1:0] addr,
   input wire dpha_ctl_type ctl,
   input wire logic [DATA_W-1:0] data_out,
   output logic [DATA_W-1:0] data_in,
   output logic busy_n,
   // Other port, played by the bench
   input wire logic busy_force,
   input wire logic [7:0] other_holds,
   input wire logic other_on,  // Other port enabled on other_addr
   input wire logic [ADDR_W-1:0] other_addr
);
   // ****************************************
   // State
   // ****************************************
   logic [DATA_W-1:0] mem [0:255];  // Only the low address bits are decoded
   logic [7:0] own = 8'h00;  // Flags this port holds
   logic [DATA_W-1:0] last = 16'h0000;  // Last word driven
   logic [ADDR_W-1:0] addr_d;  // Delayed copies: write end and data change together
   dpha_ctl_type ctl_d;
   logic [DATA_W-1:0] wd_d;
   logic wr_mem;
   logic wr_flag;
   logic rd_on;
   logic [DATA_W-1:0] rd_val;
   logic match;  // Both ports enabled on one word
   logic lose = 1'b0;  // This port arrived second

   assign #1 addr_d = addr;
   assign #1 ctl_d = ctl;
   assign #1 wd_d = data_out;

   // Write only in the overlap of enable, a lane and read/write low
   assign wr_mem = !ctl.ce_n && ctl.flag_select_n && !ctl.rw_n &&
      (!ctl.upper_lane_n || !ctl.lower_lane_n);
   assign wr_flag = ctl.ce_n && !ctl.flag_select_n && !ctl.rw_n;
   // Drive only while reading; a late enable after read/write low stays off
   assign rd_on = !ctl.oe_n && ctl.rw_n &&
      (ctl.ce_n != ctl.flag_select_n);

   // ****************************************
   // Array and flag updates at write end
   // ****************************************
   always @(negedge wr_mem) begin
      // A busied write must not touch the other port's word
      if (busy_n) begin
         if (!ctl_d.upper_lane_n) begin
            mem[addr_d[7:0]][15:8] = wd_d[15:8];
         end
         if (!ctl_d.lower_lane_n) begin
            mem[addr_d[7:0]][7:0] = wd_d[7:0];
         end
      end
   end

   always @(negedge wr_flag) begin
      if (wd_d[0]) begin
         own[addr_d[2:0]] = 1'b0;
      end else if (!other_holds[addr_d[2:0]]) begin
         own[addr_d[2:0]] = 1'b1;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always @* begin
      if (!rd_on) begin
         rd_val = ~last;
      end else if (!ctl.flag_select_n) begin
         rd_val = {DATA_W{~own[addr[2:0]]}};
      end else begin
         rd_val = mem[addr[7:0]];
      end
   end

   always @(negedge rd_on) begin
      last = data_in;
   end

   assign #(ACC_NS) data_in = rd_val;
   // ****************************************
   // Same-word arbitration against the other port
   // ****************************************
   assign match = !ctl.ce_n && other_on && (addr == other_addr);
   // Whoever stood on the word a moment before wins; a tie busies this port
   always @(posedge match) begin
      lose = !(!ctl_d.ce_n && addr_d == other_addr);
   end
   // Busy holds until the words part; the bench may also force it
   assign busy_n = !(busy_force || (match && lose));
endmodule

`default_nettype wire

// ===== dpha_host.sv
// Purpose: Host controller driving one port of an asynchronous dual-port RAM.
// Assumes: One command at a time; busy pin is sampled, never driven.
// Notes: All pin outputs come straight from flip-flops.
//
// Contract
// [R1] Read/write stays high during every read
// [R2] Flag reads strobed by select, not address
// [R3] Byte lanes picked by enables with chip enable
// [R4] Address moves only with controls high
// [R5] Device writes only in enable overlap
// [R6] Late enable keeps device outputs off
// [R7] Host data drivers off unless writing
// [R8] Chip enable high across flag write/read
// [R9] Flag request writes bit zero low
// [R10] Free flag goes to first requester
// [R11] Contention grants flag to exactly one
// [R12] Same-address race busies exactly one port
// [R13] Arbitration on enable fall or match
// [R14] Busy is an input; wait for release
// [R15] Master busies loser until mismatch
// [R16] Flag access: chip enable high, select low
// [R17] Hold read/write high until busy released
// [R18] First valid address wins arbitration
// [R19] Busied write leaves owner's word alone
// [R20] Held flag stays held until released

`timescale 1ns/10ps
`default_nettype none

module dpha_host
   import dpha_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Command side
   input wire logic cmd_valid,
   input wire dpha_cmd_type cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output dpha_rsp_type rsp,
   // Device port pins
   output logic [ADDR_W-1:0] addr,
   output dpha_ctl_type ctl,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic busy_n
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_WAIT_FREE = 3'h2,
      ST_WRITE = 3'h3,
      ST_READ = 3'h4,
      ST_GAP = 3'h5,
      ST_RECOVER = 3'h6
   } dpha_state_type;

   dpha_state_type state_reg, state_next;  // Sequencer state
   dpha_op_type op_reg, op_next;  // Operation in flight
   logic upper_reg, upper_next;  // Latched lane enables
   logic lower_reg, lower_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic [3:0] cnt_reg, cnt_next;  // Cycles left in current phase
   logic [ADDR_W-1:0] addr_next;
   dpha_ctl_type ctl_next;
   logic [DATA_W-1:0] data_out_next;
   logic data_oe_next;
   logic cmd_ready_next;
   logic rsp_valid_next;
   dpha_rsp_type rsp_next;
   logic [DATA_W:0] pins_sync;  // Busy and data after two stages
   logic busy_free;  // Busy released, write may go ahead
   logic is_flag;  // Current op targets the flag space

   // ****************************************
   // Pin input synchroniser
   // ****************************************
   dpha_sync #(.WIDTH(DATA_W + 1)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({busy_n, data_in}),
      .sync_out(pins_sync)
   );

   assign busy_free = pins_sync[DATA_W];  // R14
   assign is_flag = (op_reg != OP_READ) && (op_reg != OP_WRITE);

   // ****************************************
   // Sequencer next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      upper_next = upper_reg;
      lower_next = lower_reg;
      wdata_next = wdata_reg;
      cnt_next = cnt_reg;
      addr_next = addr;
      ctl_next = ctl;
      data_out_next = data_out;
      data_oe_next = data_oe;
      cmd_ready_next = cmd_ready;
      rsp_valid_next = 1'b0;
      rsp_next = rsp;
      unique case (state_reg)
         ST_IDLE: begin
            // Address only moves here, with every control high
            if (cmd_valid && cmd_ready) begin
               op_next = cmd.op;
               addr_next = cmd.addr;  // R4
               wdata_next = cmd.wdata;
               upper_next = cmd.upper_en;
               lower_next = cmd.lower_en;
               cmd_ready_next = 1'b0;
               state_next = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Select array or flag space; never both at once
            if (is_flag) begin
               ctl_next.ce_n = 1'b1;  // R8 R16
               ctl_next.flag_select_n = 1'b0;  // R2 R16
               ctl_next.lower_lane_n = 1'b0;
            end else begin
               ctl_next.ce_n = 1'b0;
               ctl_next.flag_select_n = 1'b1;  // R3
               ctl_next.upper_lane_n = ~upper_reg;  // R3
               ctl_next.lower_lane_n = ~lower_reg;  // R3
            end
            if (op_reg == OP_READ || op_reg == OP_SEM_READ) begin
               ctl_next.oe_n = 1'b0;  // R1
               cnt_next = ACCESS_CYC - 4'h1;
               state_next = ST_READ;
            end else begin
               cnt_next = BUSY_CYC - 4'h1;  // R17
               state_next = ST_WAIT_FREE;
            end
         end
         ST_WAIT_FREE: begin
            // Read/write stays high until busy is seen released; a stale
            // busy would let a write through that arbitration has refused
            if (cnt_reg != 4'h0) begin
               cnt_next = cnt_reg - 4'h1;  // R14
            end else if (busy_free) begin
               ctl_next.rw_n = 1'b0;  // R17 R5
               data_oe_next = 1'b1;  // R7
               // Bit zero low requests a flag, high releases it
               if (op_reg == OP_SEM_TAKE) begin
                  data_out_next = {wdata_reg[DATA_W-1:1], 1'b0};  // R9
               end else if (op_reg == OP_SEM_GIVE) begin
                  data_out_next = {wdata_reg[DATA_W-1:1], 1'b1};  // R20
               end else begin
                  data_out_next = wdata_reg;
               end
               cnt_next = WRITE_CYC - 4'h1;
               state_next = ST_WRITE;
            end
         end
         ST_WRITE: begin
            // Pulse covers both pulse width and data setup
            if (cnt_reg == 4'h0) begin
               ctl_next = CTL_IDLE;
               data_oe_next = 1'b0;
               if (op_reg == OP_SEM_TAKE) begin
                  // Flag update pulse, then read back the result
                  op_next = OP_SEM_READ;  // R8
                  cnt_next = GAP_CYC - 4'h1;
                  state_next = ST_GAP;
               end else begin
                  rsp_valid_next = 1'b1;
                  cnt_next = RECOVER_CYC - 4'h1;
                  state_next = ST_RECOVER;
               end
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_GAP: begin
            if (cnt_reg == 4'h0) begin
               state_next = ST_SETUP;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_READ: begin
            // Wait includes the synchroniser stages before capture
            if (cnt_reg == 4'h0) begin
               rsp_next.rdata = pins_sync[DATA_W-1:0];
               rsp_next.granted = is_flag && !pins_sync[0];  // R10 R11
               rsp_valid_next = 1'b1;
               ctl_next = CTL_IDLE;
               cnt_next = RECOVER_CYC - 4'h1;
               state_next = ST_RECOVER;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_RECOVER: begin
            if (cnt_reg == 4'h0) begin
               cmd_ready_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         default: begin
            ctl_next = CTL_IDLE;
            data_oe_next = 1'b0;
            cmd_ready_next = 1'b1;
            state_next = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // Sequencer registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         op_reg <= OP_READ;
         upper_reg <= 1'b0;
         lower_reg <= 1'b0;
         wdata_reg <= '0;
         cnt_reg <= 4'h0;
         addr <= '0;
         ctl <= CTL_IDLE;
         data_out <= '0;
         data_oe <= 1'b0;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         wdata_reg <= wdata_next;
         cnt_reg <= cnt_next;
         addr <= addr_next;
         ctl <= ctl_next;
         data_out <= data_out_next;
         data_oe <= data_oe_next;
         cmd_ready <= cmd_ready_next;
         rsp_valid <= rsp_valid_next;
         rsp <= rsp_next;
      end
   end

   // ****************************************
   // Checks on the pins this end drives
   // ****************************************
   sequence s_write_pulse;
      !ctl.rw_n [*3] ##1 ctl.rw_n;
   endsequence
   sequence s_flag_reread;
      ctl.flag_select_n ##[1:8] (!ctl.flag_select_n && !ctl.oe_n);
   endsequence

   property p_read_rw_high;
      @(posedge clk) disable iff (rst) !ctl.oe_n |-> ctl.rw_n;
   endproperty
   a_read_rw_high: assert property (p_read_rw_high) // R1
      else $error("read/write low during read");

   property p_flag_addr_still;
      @(posedge clk) disable iff (rst)
         (!ctl.flag_select_n && !ctl.oe_n) |-> $stable(addr);
   endproperty
   a_flag_addr_still: assert property (p_flag_addr_still) // R2
      else $error("address moved during flag read");

   property p_lane_match;
      @(posedge clk) disable iff (rst)
         !ctl.ce_n |-> (ctl.upper_lane_n == !upper_reg && ctl.lower_lane_n == !lower_reg);
   endproperty
   a_lane_match: assert property (p_lane_match) // R3
      else $error("byte lane does not match command");

   property p_addr_quiet;
      @(posedge clk) disable iff (rst) !$stable(addr) |-> (ctl.rw_n && ctl.ce_n);
   endproperty
   a_addr_quiet: assert property (p_addr_quiet) // R4
      else $error("address moved with controls active");

   property p_no_drive_on_read;
      @(posedge clk) disable iff (rst) data_oe |-> (ctl.oe_n && !ctl.rw_n);
   endproperty
   a_no_drive_on_read: assert property (p_no_drive_on_read) // R7
      else $error("data driven outside write");

   property p_take_reread;
      @(posedge clk) disable iff (rst)
         ($rose(ctl.rw_n) && !$past(ctl.flag_select_n) && op_reg == OP_SEM_READ)
            |-> s_flag_reread;
   endproperty
   a_take_reread: assert property (p_take_reread) // R8
      else $error("flag request not read back");

   property p_take_bit_low;
      @(posedge clk) disable iff (rst)
         (!ctl.rw_n && !ctl.flag_select_n && op_reg == OP_SEM_TAKE) |-> !data_out[0];
   endproperty
   a_take_bit_low: assert property (p_take_bit_low) // R9
      else $error("flag request with bit zero high");

   property p_space_exclusive;
      @(posedge clk) disable iff (rst) !ctl.flag_select_n |-> ctl.ce_n;
   endproperty
   a_space_exclusive: assert property (p_space_exclusive) // R16
      else $error("flag and array selected together");

   property p_wait_busy;
      @(posedge clk) disable iff (rst) $fell(ctl.rw_n) |-> $past(busy_free);
   endproperty
   a_wait_busy: assert property (p_wait_busy) // R17 R14
      else $error("write started while busy");

   property p_busy_settle;
      @(posedge clk) disable iff (rst) $fell(ctl.ce_n) |-> ctl.rw_n [*5];
   endproperty
   a_busy_settle: assert property (p_busy_settle) // R17
      else $error("write started before busy settled");

   property p_pulse_len;
      @(posedge clk) disable iff (rst) $fell(ctl.rw_n) |-> s_write_pulse;
   endproperty
   a_pulse_len: assert property (p_pulse_len) // R5
      else $error("write pulse length wrong");

endmodule

`default_nettype wire

// ===== dpha_host_tb.sv
// Purpose: Self-checking bench for the dual-port RAM port host.
// Assumes: Device model on the pins; bench plays the other port.
// Notes: Inputs change at the falling edge.

`timescale 1ns/10ps
`default_nettype none

module dpha_host_tb
   import dpha_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   dpha_cmd_type cmd = '0;
   logic cmd_ready, rsp_valid, data_oe, busy_n;
   dpha_rsp_type rsp, r;
   logic [ADDR_W-1:0] addr, pa;
   dpha_ctl_type ctl;
   logic [DATA_W-1:0] data_out, data_in;
   logic busy_force = 1'b0;
   logic [7:0] other_holds = 8'h00;
   logic other_on = 1'b0;
   logic [ADDR_W-1:0] other_addr = '0;
   int errors = 0;
   int n_tests = 0;

   always #4 clk = ~clk;

   dpha_host DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .addr(addr), .ctl(ctl),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .busy_n(busy_n));

   dpha_dev_model dev (.addr(addr), .ctl(ctl), .data_out(data_out), .data_in(data_in),
      .busy_n(busy_n), .busy_force(busy_force), .other_holds(other_holds),
      .other_on(other_on), .other_addr(other_addr));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic issue(input dpha_op_type op, input logic [13:0] a, input logic [15:0] wd,
      input logic ue, input logic le);
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      cmd_valid = 1'b1;
      cmd = '{op, a, wd, ue, le};
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask

   task automatic wait_rsp(input int lim);
      int k;
      k = 0;
      while (rsp_valid !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
      chk("response arrived", 16'h0001, 16'(k < lim));
      r = rsp;
   endtask

   task automatic run(input dpha_op_type op, input logic [13:0] a, input logic [15:0] wd,
      input logic ue, input logic le);
      issue(op, a, wd, ue, le);
      wait_rsp(100);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk("ctl idle", 16'(CTL_IDLE), 16'(ctl));
      chk("data_oe idle", 16'h0000, 16'(data_oe));
      chk("cmd_ready idle", 16'h0001, 16'(cmd_ready));
   endtask

   // Byte lanes, a write with no lane, back-to-back reads
   task automatic t_array();
      run(OP_WRITE, 14'h0005, 16'ha5c3, 1'b1, 1'b1);
      run(OP_WRITE, 14'h0005, 16'h11ee, 1'b1, 1'b0);
      run(OP_WRITE, 14'h0009, 16'h0f0f, 1'b1, 1'b1);
      run(OP_WRITE, 14'h0009, 16'hffff, 1'b0, 1'b0);
      run(OP_READ, 14'h0005, 16'h0000, 1'b1, 1'b1);
      chk("upper lane only", 16'h11c3, r.rdata);
      run(OP_READ, 14'h0009, 16'h0000, 1'b1, 1'b1);
      chk("no lane write", 16'h0f0f, r.rdata);
   endtask

   // Take every flag, one held by the other side, then give flag 2 back
   task automatic t_flags();
      other_holds = 8'h08;
      for (int i = 0; i < 8; i++) begin
         run(OP_SEM_TAKE, 14'(i), 16'hffff, 1'b0, 1'b1);
         chk("flag take", 16'(i != 3), 16'(r.granted));
      end
      run(OP_SEM_READ, 14'h0002, 16'h0000, 1'b0, 1'b1);
      chk("flag still held", 16'h0001, 16'(r.granted));
      run(OP_SEM_GIVE, 14'h0002, 16'h0000, 1'b0, 1'b1);
      run(OP_SEM_READ, 14'h0002, 16'h0000, 1'b0, 1'b1);
      chk("flag released", 16'h0000, 16'(r.granted));
      other_holds = 8'h00;
   endtask

   // Write held off by busy, completed after release
   task automatic t_busy();
      int bad;
      bad = 0;
      busy_force = 1'b1;
      issue(OP_WRITE, 14'h0007, 16'h3c5a, 1'b1, 1'b1);
      repeat (20) begin
         @(negedge clk);
         if (ctl.rw_n !== 1'b1 || rsp_valid !== 1'b0) bad++;
      end
      chk("write held while busy", 16'h0000, 16'(bad));
      busy_force = 1'b0;
      wait_rsp(20);
      run(OP_READ, 14'h0007, 16'h0000, 1'b1, 1'b1);
      chk("write after busy", 16'h3c5a, r.rdata);
   endtask

   // Other port on the word first holds the write off; arriving second it does not
   task automatic t_arbit();
      int bad;
      bad = 0;
      other_addr = 14'h000b;
      other_on = 1'b1;
      issue(OP_WRITE, 14'h000b, 16'h5aa5, 1'b1, 1'b1);
      repeat (12) begin
         @(negedge clk);
         if (ctl.rw_n !== 1'b1 || rsp_valid !== 1'b0) bad++;
      end
      chk("write held by arbitration", 16'h0000, 16'(bad));
      other_on = 1'b0;
      wait_rsp(20);
      run(OP_READ, 14'h000b, 16'h0000, 1'b1, 1'b1);
      chk("write after arbitration", 16'h5aa5, r.rdata);
      other_addr = 14'h000c;
      issue(OP_WRITE, 14'h000c, 16'hc3c3, 1'b1, 1'b1);
      @(negedge clk);
      other_on = 1'b1;
      wait_rsp(20);
      other_on = 1'b0;
      run(OP_READ, 14'h000c, 16'h0000, 1'b1, 1'b1);
      chk("first port keeps access", 16'hc3c3, r.rdata);
   endtask

   // Reset in mid-command: pins fall back to idle and no answer follows
   task automatic t_midreset();
      busy_force = 1'b1;
      issue(OP_WRITE, 14'h0003, 16'h1234, 1'b1, 1'b1);
      repeat (3) @(negedge clk);
      rst = 1'b1;
      repeat (5) @(negedge clk);
      busy_force = 1'b0;
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_reset();
      chk("no answer after reset", 16'h0000, 16'(rsp_valid));
      run(OP_READ, 14'h0005, 16'h0000, 1'b1, 1'b1);
      chk("read after reset", 16'h11c3, r.rdata);
   endtask

   // ****************************************
   // Pin monitor
   // ****************************************
   always @(negedge clk) begin
      if (!rst) begin
         if (data_oe && !(ctl.oe_n && !ctl.rw_n)) begin
            errors++;
            $display("FAIL data_oe expected 0 seen 1");
         end
         if (!ctl.oe_n && !ctl.rw_n) begin
            errors++;
            $display("FAIL rw_n expected 1 seen 0");
         end
         if (!ctl.ce_n && !ctl.flag_select_n) begin
            errors++;
            $display("FAIL ce_n expected 1 seen 0");
         end
         if (addr !== pa && !(ctl.ce_n && ctl.rw_n)) begin
            errors++;
            $display("FAIL addr expected %h seen %h", pa, addr);
         end
      end
      pa <= addr;
   end

   // ****************************************
   // Run control
   // ****************************************
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Tests need well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("FAIL watchdog expected done seen hang");
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_reset();
      t_array();
      t_flags();
      t_busy();
      t_arbit();
      t_midreset();
      end_of_test();
   end
endmodule

`default_nettype wire

// ===== dpha_pkg.sv
// Purpose: Shared constants and types for the dual-port RAM port host.
// Assumes: 125 MHz clock; widest part of the family (14 address bits, 16 data bits).
// Notes: Timing counts other than RECOVER_CYC are derived from the printed nanosecond figures.

package dpha_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W = 14;  // Address pins
   localparam int DATA_W = 16;  // Data pins
   localparam int SYNC_STAGES = 2;  // Flip-flops on every pin input

   // ****************************************
   // Timing, in ns and in clock cycles
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_ACCESS_NS = 25;  // Slowest access time, array or flag
   localparam int T_PWE_NS = 20;  // Write pulse width
   localparam int T_SD_NS = 15;  // Data setup to write end
   localparam int T_SOP_NS = 12;  // Flag update pulse
   localparam int T_SWRD_NS = 5;  // Flag write to read time
   // Least times round up; the pin synchroniser adds its own stages on reads
   localparam logic [3:0] ACCESS_CYC =
      4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [3:0] PWE_CYC = 4'((T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] SD_CYC = 4'((T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WRITE_CYC = (PWE_CYC > SD_CYC) ? PWE_CYC : SD_CYC;
   localparam int GAP_NS = (T_SOP_NS > T_SWRD_NS) ? T_SOP_NS : T_SWRD_NS;
   localparam logic [3:0] GAP_CYC = 4'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RECOVER_CYC = 4'h1;  // Idle cycle between accesses
   localparam int T_BLC_NS = 20;  // Busy valid after enable low or address match
   // Busy answers our own enable late and then crosses the synchroniser
   localparam logic [3:0] BUSY_CYC =
      4'((T_BLC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      OP_READ = 3'h0,  // Array read
      OP_WRITE = 3'h1,  // Array write
      OP_SEM_TAKE = 3'h2,  // Request flag, then read it back
      OP_SEM_GIVE = 3'h3,  // Release flag
      OP_SEM_READ = 3'h4  // Read flag state only
   } dpha_op_type;

   typedef struct packed {
      dpha_op_type op;
      logic [ADDR_W-1:0] addr;  // Flag index sits in the low bits
      logic [DATA_W-1:0] wdata;
      logic upper_en;  // Array byte lanes
      logic lower_en;
   } dpha_cmd_type;

   typedef struct packed {
      logic ce_n;
      logic rw_n;
      logic oe_n;
      logic flag_select_n;
      logic upper_lane_n;
      logic lower_lane_n;
   } dpha_ctl_type;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic granted;  // Flag read back low: this port owns it
   } dpha_rsp_type;

   localparam dpha_ctl_type CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ===== dpha_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: Only the second stage is visible outside.

`timescale 1ns/10ps
`default_nettype none

module dpha_sync
   import dpha_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg;  // Read by the second stage only

   // ****************************************
   // Two stages, cleared by reset
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1_reg <= '0;
         sync_out <= '0;
      end else begin
         stage1_reg <= async_in;
         sync_out <= stage1_reg;
      end
   end

endmodule

`default_nettype wire
